// *** shared/sdp_defines.svh ***
// Constants for the dual-port synchronous RAM port logic
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

`define SDP_ADDR_W 13
`define SDP_DATA_W 18
`define SDP_HALF_W 9

`define SDP_CLK_PERIOD_NS 40
`define SDP_XPORT_WR_RD_DELAY_NS 40
`define SDP_XPORT_WR_RD_DELAY_CYC ((`SDP_XPORT_WR_RD_DELAY_NS) / (`SDP_CLK_PERIOD_NS))
`define SDP_XPORT_CLK_SPACING_NS 15

`define SDP_REG_CTRL 4'h0
`define SDP_REG_STATUS 4'h4
`define SDP_REG_CNT0 4'h8
`define SDP_REG_CNT1 4'hC

`define SDP_CTRL_COLL_EN_BIT 0
`define SDP_CTRL_COLL_EN_RST 1'b1
`define SDP_STAT_COLL_BIT 0
`define SDP_STAT_LAT0_BIT 1
`define SDP_STAT_LAT1_BIT 2

`endif

// *** shared/sdp_pkg.sv ***
// Types shared by the dual-port synchronous RAM port logic
package sdp_pkg;

	typedef enum logic [3:0] {
		SDP_CNT_CLEAR = 4'h1,
		SDP_CNT_LOAD = 4'h2,
		SDP_CNT_HOLD = 4'h4,
		SDP_CNT_INCR = 4'h8
	} sdp_cnt_op_t;

	typedef logic [1:0] sdp_half_t;

endpackage : sdp_pkg

// *** verif/sdp_host_model.sv ***
// Host bus model driving both RAM ports
module sdp_host_model (
	input wire logic clk_sys_in,
	output logic [1:0][12:0] addr_out,
	output logic [1:0] strb_n_out,
	output logic [1:0] adv_n_out,
	output logic [1:0] clr_n_out,
	output logic [1:0] sel_n_out,
	output logic [1:0] sel_out,
	output logic [1:0] rw_n_out,
	output logic [1:0] lo_n_out,
	output logic [1:0] hi_n_out,
	output logic [1:0] oe_n_out,
	output logic [1:0] lat_out,
	output logic [1:0][17:0] wd_out
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	task automatic idle(input int p);
		{clr_n_out[p], strb_n_out[p], adv_n_out[p]} <= 3'h7;
		sel_n_out[p] <= 1'h1;
		sel_out[p] <= 1'h0;
		rw_n_out[p] <= 1'h1;
		// Released data shows no stale value
		wd_out[p] <= ~wd_out[p];
	endtask : idle

	task automatic mode(input int p, input logic oe_n, input logic lat);
		oe_n_out[p] <= oe_n;
		lat_out[p] <= lat;
	endtask : mode

	// One command held across its sampling edge
	task automatic op(input int p, input logic [2:0] c, input logic s, input logic rw,
			input logic [1:0] b, input logic [12:0] a, input logic [17:0] d);
		{clr_n_out[p], strb_n_out[p], adv_n_out[p]} <= c;
		sel_n_out[p] <= !s;
		sel_out[p] <= s;
		rw_n_out[p] <= rw;
		{hi_n_out[p], lo_n_out[p]} <= b;
		addr_out[p] <= a;
		wd_out[p] <= d;
		@(posedge clk_sys_in);
		idle(p);
	endtask : op

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		addr_out = '0;
		wd_out = '0;
		lo_n_out = 2'h0;
		hi_n_out = 2'h0;
		oe_n_out = 2'h0;
		lat_out = 2'h0;
		clr_n_out = 2'h3;
		strb_n_out = 2'h3;
		adv_n_out = 2'h3;
		sel_n_out = 2'h3;
		sel_out = 2'h0;
		rw_n_out = 2'h3;
	end
endmodule : sdp_host_model

// *** verif/test_sdp_port_ram.sv ***
// Self-checking bench for the two-port RAM logic
`include "sdp_defines.svh"
module test_sdp_port_ram;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'h0;
	logic resetn_in = 1'h0;
	logic [1:0][12:0] addr;
	logic [1:0] strb_n, adv_n, clr_n, sel_n, sel, rw_n, lo_n, hi_n, oe_n, lat;
	logic [1:0][17:0] wd, dout;
	logic [1:0][1:0] doe;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rv;
	logic avs_waitrequest;
	int mismatches = 0;
	int checked = 0;

	sdp_host_model sdp_host_model_inst (
		.clk_sys_in(clk_sys_in),
		.addr_out(addr),
		.strb_n_out(strb_n),
		.adv_n_out(adv_n),
		.clr_n_out(clr_n),
		.sel_n_out(sel_n),
		.sel_out(sel),
		.rw_n_out(rw_n),
		.lo_n_out(lo_n),
		.hi_n_out(hi_n),
		.oe_n_out(oe_n),
		.lat_out(lat),
		.wd_out(wd)
	);

	sdp_port_ram sdp_port_ram_inst (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.addr_in(addr),
		.addr_load_strobe_n_in(strb_n),
		.count_advance_n_in(adv_n),
		.count_clear_n_in(clr_n),
		.select_low_active_n_in(sel_n),
		.select_high_active_in(sel),
		.rd_wr_n_in(rw_n),
		.low_half_select_n_in(lo_n),
		.high_half_select_n_in(hi_n),
		.out_enable_n_in(oe_n),
		.latency_select_in(lat),
		.wdata_in(wd),
		.data_out(dout),
		.data_oe_out(doe),
		.avs_address_in(avs_address),
		.avs_read_in(avs_read),
		.avs_write_in(avs_write),
		.avs_writedata_in(avs_writedata),
		.avs_byteenable_in(4'hF),
		.avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys_in); while (avs_waitrequest !== 1'h0);
		rv = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : av

	// Selected command, then look after its sampling edge
	task automatic go(input int p, input logic [2:0] c, input logic rw, input logic [1:0] b,
			input logic [12:0] a, input logic [17:0] d);
		@(posedge clk_sys_in);
		sdp_host_model_inst.op(p, c, 1'h1, rw, b, a, d);
		@(negedge clk_sys_in);
	endtask : go

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("reset drive", 32'h0, 32'(doe));
		chk("waitrequest idle", 32'h1, 32'(avs_waitrequest));
		av(1'h0, `SDP_REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rv);
		av(1'h1, `SDP_REG_CTRL, 32'h0);
		av(1'h0, `SDP_REG_CTRL, 32'h0);
		chk("ctrl written", 32'h0, rv);
		av(1'h0, 4'h2, 32'h0);
		chk("unmapped read", 32'h0, rv);
	endtask : t_reset

	task automatic t_flow;
		go(0, 3'h5, 1'h0, 2'h0, 13'h5, 18'h2A5A5);
		chk("write drive", 32'h0, 32'(doe[0]));
		go(0, 3'h5, 1'h1, 2'h0, 13'h5, 18'h0);
		chk("ft read", 32'h2A5A5, 32'(dout[0]));
		chk("ft drive", 32'h3, 32'(doe[0]));
		@(negedge clk_sys_in);
		chk("ft deselect", 32'h0, 32'(doe[0]));
		go(0, 3'h5, 1'h0, 2'h2, 13'h5, 18'h0);
		go(0, 3'h5, 1'h1, 2'h1, 13'h5, 18'h0);
		chk("high half", 32'h152, 32'(dout[0][17:9]));
		chk("half drive", 32'h2, 32'(doe[0]));
		@(posedge clk_sys_in);
		sdp_host_model_inst.mode(0, 1'h1, 1'h0);
		go(0, 3'h5, 1'h1, 2'h0, 13'h5, 18'h0);
		chk("low half", 32'h2A400, 32'(dout[0]));
		chk("oe blocks drive", 32'h0, 32'(doe[0]));
	endtask : t_flow

	task automatic t_pipe;
		@(posedge clk_sys_in);
		sdp_host_model_inst.mode(0, 1'h0, 1'h1);
		go(0, 3'h5, 1'h0, 2'h0, 13'h6, 18'h0F0F0);
		go(0, 3'h5, 1'h1, 2'h0, 13'h6, 18'h0);
		chk("pipe early", 32'h0, 32'(doe[0]));
		chk("pipe early data", 32'h2A400, 32'(dout[0]));
		@(negedge clk_sys_in);
		chk("pipe read", 32'h0F0F0, 32'(dout[0]));
		chk("pipe drive", 32'h3, 32'(doe[0]));
		@(negedge clk_sys_in);
		chk("pipe deselect", 32'h0, 32'(doe[0]));
		@(posedge clk_sys_in);
		sdp_host_model_inst.mode(0, 1'h0, 1'h0);
	endtask : t_pipe

	task automatic t_count;
		go(1, 3'h5, 1'h0, 2'h0, 13'h1FFE, 18'h11111);
		go(1, 3'h5, 1'h0, 2'h0, 13'h1FFF, 18'h22222);
		go(1, 3'h5, 1'h0, 2'h0, 13'h0, 18'h33333);
		go(1, 3'h5, 1'h1, 2'h0, 13'h1FFE, 18'h0);
		chk("load read", 32'h11111, 32'(dout[1]));
		go(1, 3'h6, 1'h1, 2'h0, 13'h5, 18'h0);
		chk("advance read", 32'h22222, 32'(dout[1]));
		go(1, 3'h7, 1'h1, 2'h0, 13'h5, 18'h0);
		chk("hold read", 32'h22222, 32'(dout[1]));
		@(posedge clk_sys_in);
		sdp_host_model_inst.op(1, 3'h6, 1'h0, 1'h1, 2'h0, 13'h5, 18'h0);
		av(1'h0, `SDP_REG_CNT1, 32'h0);
		chk("wrapped count", 32'h0, rv);
		go(1, 3'h5, 1'h1, 2'h0, 13'h1FFE, 18'h0);
		go(1, 3'h1, 1'h1, 2'h0, 13'h1FFE, 18'h0);
		chk("clear read", 32'h33333, 32'(dout[1]));
		av(1'h0, `SDP_REG_CNT1, 32'h0);
		chk("cleared count", 32'h0, rv);
	endtask : t_count

	task automatic t_cross;
		@(posedge clk_sys_in);
		fork
			sdp_host_model_inst.op(0, 3'h5, 1'h1, 1'h0, 2'h0, 13'h7, 18'h2BCDE);
			sdp_host_model_inst.op(1, 3'h5, 1'h1, 1'h1, 2'h0, 13'h7, 18'h0);
		join
		@(negedge clk_sys_in);
		chk("cross read", 32'h2BCDE, 32'(dout[1]));
	endtask : t_cross

	// Deliberate clash: both ports write one word in one cycle
	task automatic t_clash;
		av(1'h1, `SDP_REG_CTRL, 32'h1);
		@(posedge clk_sys_in);
		fork
			sdp_host_model_inst.op(0, 3'h5, 1'h1, 1'h0, 2'h0, 13'h9, 18'h12345);
			sdp_host_model_inst.op(1, 3'h5, 1'h1, 1'h0, 2'h0, 13'h9, 18'h0ABCD);
		join
		av(1'h0, `SDP_REG_STATUS, 32'h0);
		chk("clash flag", 32'h1, rv);
		av(1'h1, `SDP_REG_STATUS, 32'h1);
		av(1'h0, `SDP_REG_STATUS, 32'h0);
		chk("clash cleared", 32'h0, rv);
		go(0, 3'h5, 1'h1, 2'h0, 13'h9, 18'h0);
		chk("clash winner", 32'h0ABCD, 32'(dout[0]));
	endtask : t_clash

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	initial begin
		repeat (2000) @(posedge clk_sys_in);
		mismatches++;
		complete_run;
	end

	initial begin
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'h1;
		t_reset;
		t_flow;
		t_pipe;
		t_count;
		t_cross;
		t_clash;
		complete_run;
	end
endmodule : test_sdp_port_ram

// *** verilog/sdp_burst_cnt.sv ***
// Burst address counter of one RAM port
module sdp_burst_cnt
	import sdp_pkg::*;
#(
	parameter int AW = 13
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [AW-1:0] ext_addr_in,
	input wire logic addr_load_strobe_n_in,
	input wire logic count_advance_n_in,
	input wire logic count_clear_n_in,
	output logic [AW-1:0] access_addr_out,
	output logic [AW-1:0] count_out
);

	sdp_cnt_op_t op;
	logic [AW-1:0] count_q;
	logic [AW-1:0] count_d;

	always_comb begin
		if (!count_clear_n_in) begin
			op = SDP_CNT_CLEAR;
		end else if (!addr_load_strobe_n_in) begin
			op = SDP_CNT_LOAD;
		end else if (!count_advance_n_in) begin
			op = SDP_CNT_INCR;
		end else begin
			op = SDP_CNT_HOLD;
		end
	end

	always_comb begin
		unique case (op)
			SDP_CNT_CLEAR: count_d = '0;
			SDP_CNT_LOAD: count_d = ext_addr_in;
			SDP_CNT_INCR: count_d = count_q + 1'b1;
			SDP_CNT_HOLD: count_d = count_q;
			default: count_d = count_q;
		endcase
	end

	// Access uses the address of this very edge, so no idle cycle
	assign access_addr_out = count_d;
	assign count_out = count_q;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	a_cnt_clear_zero: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!count_clear_n_in |=> count_q == '0
	) else $error("counter not cleared to zero");

	a_cnt_load_ext: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		count_clear_n_in && !addr_load_strobe_n_in |=> count_q == $past(ext_addr_in)
	) else $error("counter did not load external address");

	a_cnt_hold_value: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		count_clear_n_in && addr_load_strobe_n_in && count_advance_n_in |=> $stable(count_q)
	) else $error("counter moved while holding");

	a_cnt_step_one: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		count_clear_n_in && addr_load_strobe_n_in && !count_advance_n_in
			|=> count_q == $past(count_q) + 1'b1
	) else $error("counter did not advance by one");

endmodule : sdp_burst_cnt

// *** verilog/sdp_out_stage.sv ***
// Flow-through and pipelined read output stage of one RAM port
module sdp_out_stage
	import sdp_pkg::*;
#(
	parameter int DW = 18
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic rd_sel_in,
	input wire sdp_half_t half_en_in,
	input wire logic [DW-1:0] rdata_in,
	input wire logic latency_select_in,
	input wire logic out_enable_n_in,
	output logic [DW-1:0] data_out,
	output sdp_half_t data_oe_out
);

	logic [DW-1:0] s1_data_q;
	logic [DW-1:0] s1_data_d;
	logic [DW-1:0] s2_data_q;
	logic [DW-1:0] s2_data_d;
	sdp_half_t s1_drv_q;
	sdp_half_t s1_drv_d;
	sdp_half_t s2_drv_q;
	sdp_half_t s2_drv_d;

	always_comb begin
		s1_data_d = rd_sel_in ? rdata_in : s1_data_q;
		s1_drv_d = rd_sel_in ? half_en_in : 2'h0;
		s2_data_d = s1_data_q;
		s2_drv_d = s1_drv_q;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_data_q <= '0;
			s1_drv_q <= 2'h0;
			s2_data_q <= '0;
			s2_drv_q <= 2'h0;
		end else begin
			s1_data_q <= s1_data_d;
			s1_drv_q <= s1_drv_d;
			s2_data_q <= s2_data_d;
			s2_drv_q <= s2_drv_d;
		end
	end

	// Low bypasses the output register
	assign data_out = latency_select_in ? s2_data_q : s1_data_q;
	// Output enable gates the drivers without a clock
	assign data_oe_out = (latency_select_in ? s2_drv_q : s1_drv_q)
		& {2{~out_enable_n_in}};

	a_ft_deselect_z: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!latency_select_in && !rd_sel_in ##1 !latency_select_in |-> data_oe_out == 2'h0
	) else $error("flow-through port still driving after deselect");

	a_pipe_one_late: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		rd_sel_in && latency_select_in ##1 latency_select_in ##1 latency_select_in
			|-> data_out == $past(rdata_in, 2)
	) else $error("pipelined data not one cycle after flow-through");

	a_pipe_prev_ctrl: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		latency_select_in && !rd_sel_in ##1 latency_select_in
			|-> ##1 (!latency_select_in || data_oe_out == 2'h0)
	) else $error("pipelined drive not set by previous cycle");

endmodule : sdp_out_stage

// *** verilog/sdp_port_ram.sv ***
// Two synchronous ports on one 18-bit RAM array, with a status slave
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`include "sdp_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Controls sampled on rising edge; output enable immediate.
// - Deselect sampled turns outputs off after edge.
// - Pipelined: select change acts one cycle later.
// - Pipelined read data one cycle after flow-through.
// - Count clear sets counter zero, overrides all.
// - Strobe low loads external address, ignores advance.
// - All three high: counter holds, same location.
// - Advance low with strobe high: increment, use it.
// - Counter works regardless of chip selects.
// - Counter clear costs no idle cycle.
// - Array address: zero when clear low, else external when strobe low, else counter.
// - Pipelined output state follows previous cycle controls.
// - Cross-port write visible to flow-through read within 40ns.
// - Read/write low writes, high reads when selected.
// - Byte selects gate each nine-bit half.
// - Latency select low flow-through, high pipelined.
// - Counter spans array and wraps to zero.
module sdp_port_ram
	import sdp_pkg::*;
#(
	parameter int AW = `SDP_ADDR_W,
	parameter int DW = `SDP_DATA_W
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [1:0][AW-1:0] addr_in,
	input wire logic [1:0] addr_load_strobe_n_in,
	input wire logic [1:0] count_advance_n_in,
	input wire logic [1:0] count_clear_n_in,
	input wire logic [1:0] select_low_active_n_in,
	input wire logic [1:0] select_high_active_in,
	input wire logic [1:0] rd_wr_n_in,
	input wire logic [1:0] low_half_select_n_in,
	input wire logic [1:0] high_half_select_n_in,
	input wire logic [1:0] out_enable_n_in,
	input wire logic [1:0] latency_select_in,
	input wire logic [1:0][DW-1:0] wdata_in,
	output logic [1:0][DW-1:0] data_out,
	output logic [1:0][1:0] data_oe_out,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);

	localparam int DEPTH = 1 << AW;
	localparam int HW = DW / 2;

	logic [DW-1:0] mem_q [DEPTH];

	logic [1:0][AW-1:0] acc_addr;
	logic [1:0][AW-1:0] cnt_val;
	logic [1:0] rd;
	logic [1:0][1:0] half_en;
	logic [1:0][1:0] wr_half;
	logic coll_evt;

	////////////////////////////////////////////////////////////////////////////
	// Per-port decode, counter, forwarding and output stage

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int Q = 1 - p;

		logic sel;
		logic [DW-1:0] fwd_word;

		// No select input: counter runs while deselected
		sdp_burst_cnt #(
			.AW(AW)
		) u_cnt (
			.clk_sys_in(clk_sys_in),
			.resetn_in(resetn_in),
			.ext_addr_in(addr_in[p]),
			.addr_load_strobe_n_in(addr_load_strobe_n_in[p]),
			.count_advance_n_in(count_advance_n_in[p]),
			.count_clear_n_in(count_clear_n_in[p]),
			.access_addr_out(acc_addr[p]),
			.count_out(cnt_val[p])
		);

		assign sel = !select_low_active_n_in[p] && select_high_active_in[p];
		assign half_en[p] = ~{high_half_select_n_in[p], low_half_select_n_in[p]};
		assign rd[p] = sel && rd_wr_n_in[p];
		assign wr_half[p] = (sel && !rd_wr_n_in[p]) ? half_en[p] : 2'h0;

		// Same-edge write from the far port is passed straight through
		always_comb begin
			fwd_word = mem_q[acc_addr[p]];
			for (int h = 0; h < 2; h++) begin
				if (wr_half[Q][h] && acc_addr[Q] == acc_addr[p]) begin
					fwd_word[h*HW +: HW] = wdata_in[Q][h*HW +: HW];
				end
			end
		end

		sdp_out_stage #(
			.DW(DW)
		) u_out (
			.clk_sys_in(clk_sys_in),
			.resetn_in(resetn_in),
			.rd_sel_in(rd[p]),
			.half_en_in(half_en[p]),
			.rdata_in(fwd_word),
			.latency_select_in(latency_select_in[p]),
			.out_enable_n_in(out_enable_n_in[p]),
			.data_out(data_out[p]),
			.data_oe_out(data_oe_out[p])
		);

		a_addr_ext_load: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			count_clear_n_in[p] && !addr_load_strobe_n_in[p] |-> acc_addr[p] == addr_in[p]
		) else $error("strobe low but array address not external");

		a_addr_cnt_hold: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			count_clear_n_in[p] && addr_load_strobe_n_in[p] && count_advance_n_in[p]
				|-> acc_addr[p] == cnt_val[p]
		) else $error("hold access not at counter address");

		a_addr_cnt_step: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			count_clear_n_in[p] && addr_load_strobe_n_in[p] && !count_advance_n_in[p]
				|-> acc_addr[p] == cnt_val[p] + 1'b1
		) else $error("advance access not at next address");

		a_clear_no_gap: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			!count_clear_n_in[p] |-> acc_addr[p] == '0
		) else $error("clear cycle not accessing address zero");

		a_clear_read_drives: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			!count_clear_n_in[p] && rd[p] ##1 !latency_select_in[p] && !out_enable_n_in[p]
				|-> data_oe_out[p] == $past(half_en[p])
		) else $error("read lost in counter clear cycle");

		a_no_stray_write: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			!sel || rd_wr_n_in[p] |-> wr_half[p] == 2'h0
		) else $error("write strobe without selected write");

		a_half_gates_write: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			sel && !rd_wr_n_in[p] |-> wr_half[p] == half_en[p]
		) else $error("write halves differ from byte selects");

		a_oe_gates_drive: assert property (
			@(posedge clk_sys_in) disable iff (!resetn_in)
			out_enable_n_in[p] |-> data_oe_out[p] == 2'h0
		) else $error("port drives with output enable high");
	end

	////////////////////////////////////////////////////////////////////////////
	// Array: byte-lane writes, port 1 lands last on a clash

	always_ff @(posedge clk_sys_in) begin
		for (int p = 0; p < 2; p++) begin
			for (int h = 0; h < 2; h++) begin
				if (wr_half[p][h]) begin
					mem_q[acc_addr[p]][h*HW +: HW] <= wdata_in[p][h*HW +: HW];
				end
			end
		end
	end

	// Both ports writing one half of one word: collision, port 1 value is kept
	assign coll_evt = |(wr_half[0] & wr_half[1]) && acc_addr[0] == acc_addr[1];

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then answer

	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic coll_en_q;
	logic coll_en_d;
	logic coll_q;
	logic coll_d;
	logic [31:0] reg_val;
	logic req;
	logic wr_done;

	assign req = avs_read_in || avs_write_in;
	assign wr_done = avs_write_in && !wait_q;

	always_comb begin
		unique case (avs_address_in)
			`SDP_REG_CTRL: begin
				reg_val = 32'h0;
				reg_val[`SDP_CTRL_COLL_EN_BIT] = coll_en_q;
			end
			`SDP_REG_STATUS: begin
				reg_val = 32'h0;
				reg_val[`SDP_STAT_COLL_BIT] = coll_q;
				reg_val[`SDP_STAT_LAT0_BIT] = latency_select_in[0];
				reg_val[`SDP_STAT_LAT1_BIT] = latency_select_in[1];
			end
			`SDP_REG_CNT0: reg_val = 32'(cnt_val[0]);
			`SDP_REG_CNT1: reg_val = 32'(cnt_val[1]);
			default: reg_val = 32'h0;
		endcase
	end

	always_comb begin
		wait_d = !(req && wait_q);
		rdata_d = rdata_q;
		if (avs_read_in && wait_q) begin
			rdata_d = reg_val;
		end
		coll_en_d = coll_en_q;
		if (wr_done && avs_address_in == `SDP_REG_CTRL && avs_byteenable_in[0]) begin
			coll_en_d = avs_writedata_in[`SDP_CTRL_COLL_EN_BIT];
		end
		coll_d = coll_q;
		if (wr_done && avs_address_in == `SDP_REG_STATUS && avs_byteenable_in[0]
				&& avs_writedata_in[`SDP_STAT_COLL_BIT]) begin
			coll_d = 1'b0;
		end
		// A new clash beats a clear in the same cycle
		if (coll_evt && coll_en_q) begin
			coll_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
			coll_en_q <= `SDP_CTRL_COLL_EN_RST;
			coll_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			coll_en_q <= coll_en_d;
			coll_q <= coll_d;
		end
	end

	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = wait_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_wr_lands_array: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		wr_half[0][0] && !wr_half[1][0]
			|=> mem_q[$past(acc_addr[0])][HW-1:0] == $past(wdata_in[0][HW-1:0])
	) else $error("port 0 low half write not stored");

	a_xport_fwd_data: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!latency_select_in[1] && rd[1] && half_en[1][0] && wr_half[0][0]
			&& acc_addr[0] == acc_addr[1] ##1 !latency_select_in[1]
			|-> data_out[1][HW-1:0] == $past(wdata_in[0][HW-1:0])
	) else $error("cross-port write not seen by flow-through read");

	a_avl_one_wait: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		req && wait_q |=> !wait_q ##1 wait_q
	) else $error("bus answer not exactly one cycle long");

	a_coll_flag_set: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		coll_evt && coll_en_q |=> coll_q
	) else $error("collision not flagged");

	a_port1_wr_lands: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		wr_half[1][1]
			|=> mem_q[$past(acc_addr[1])][DW-1:HW] == $past(wdata_in[1][DW-1:HW])
	) else $error("port 1 high half write not stored");

	a_rdata_taken: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		avs_read_in && wait_q |=> avs_readdata_out == $past(reg_val)
	) else $error("read data not the addressed register");

	a_wait_idle: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		!req && wait_q |=> wait_q
	) else $error("waitrequest dropped without a request");

	a_coll_w1c: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		wr_done && avs_address_in == `SDP_REG_STATUS && avs_byteenable_in[0]
			&& avs_writedata_in[`SDP_STAT_COLL_BIT] && !coll_evt |=> !coll_q
	) else $error("collision flag not cleared by write of one");

	a_ctrl_write: assert property (
		@(posedge clk_sys_in) disable iff (!resetn_in)
		wr_done && avs_address_in == `SDP_REG_CTRL && avs_byteenable_in[0]
			|=> coll_en_q == $past(avs_writedata_in[`SDP_CTRL_COLL_EN_BIT])
	) else $error("collision enable not written");

endmodule : sdp_port_ram
